// ===== cis_pkg.sv
package cis_pkg;
	localparam int CIS_CLK_HZ = 40000000;
	localparam int CIS_EXT_N = 2;
	localparam int CIS_PERI_N = 6;
	localparam int CIS_SRC_N = CIS_EXT_N + CIS_PERI_N;
	localparam int CIS_NAND_W = 8;
	localparam logic [15:0] CIS_VEC_RESET = 16'hfffe;
	localparam logic [15:0] CIS_VEC_TRAP = 16'hfffc;
	localparam logic [15:0] CIS_VEC_BASE = 16'hfffa;
	localparam logic [15:0] CIS_VEC_STEP = 16'h0002;
	localparam logic [2:0] CIS_VEC_FETCH_CYC = 3'h2;
	localparam logic [2:0] CIS_PUSH_BYTES = 3'h5;
	localparam logic [7:0] CIS_CCR_RESET = 8'he8;
	localparam int CIS_CCR_I = 3;
	localparam logic [CIS_SRC_N-1:0] CIS_HALT_WAKE = 8'h03;
	localparam logic [7:0] CIS_SP_RESET = 8'h7f;
	localparam logic [7:0] CIS_SP_STACK_MSB = 8'h01;
	localparam logic [1:0] CIS_SENS_FALL_LOW = 2'h0;
	localparam logic [1:0] CIS_SENS_RISE = 2'h1;
	localparam logic [1:0] CIS_SENS_FALL = 2'h2;
	localparam logic [1:0] CIS_SENS_BOTH = 2'h3;
	localparam logic [11:0] CIS_APB_CCR = 12'h000;
	localparam logic [11:0] CIS_APB_MISC = 12'h004;
	localparam logic [11:0] CIS_APB_PEN = 12'h008;
	localparam logic [11:0] CIS_APB_PFLAG = 12'h00c;
	localparam logic [11:0] CIS_APB_PINEN = 12'h010;
	localparam logic [11:0] CIS_APB_STAT = 12'h014;
	localparam logic [11:0] CIS_APB_SP = 12'h018;
	typedef enum logic [2:0] {
		CIS_RUN, CIS_PUSH, CIS_VEC, CIS_POP, CIS_WAIT, CIS_HALT
	} cis_state_t;
endpackage

// ===== cis_sequencer.sv
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
// How it works
// - maskable sources plus one software trap
// - maskable serviced only with mask clear
// - reset leaves interrupt mask set
// - entry waits for instruction end
// - push pc, x, a, ccr; not y
// - entry sets interrupt mask
// - load vector of selected source
// - return pops context, mask cleared
// - routine not preempted while mask set
// - lowest source index wins priority
// - any source ends wait
// - only capable sources end halt
// - trap ignores mask, same entry
// - external vector needs event and clear mask
// - misc register selects pin sensitivity
// - edge latch cleared on routine entry
// - shared-vector pins combined by nand
// - any low enabled pin masks request
// - peripheral needs mask clear and enable
// - unmet condition keeps flag pending
// - clear sequence drops pending latch
// - reset vector top word, two-cycle fetch
// - halt entry clears interrupt mask
// - wait entry clears interrupt mask
// - cleared mask in routine lets pending in
module cis_sequencer
	import cis_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [CIS_NAND_W-1:0] pin_a_in,
	input wire logic [CIS_NAND_W-1:0] pin_b_in,
	input wire logic [CIS_PERI_N-1:0] peri_event_in,
	input wire logic [CIS_PERI_N-1:0] peri_assoc_in,
	input wire logic instr_end_in,
	input wire logic trap_in,
	input wire logic return_from_interrupt_instruction_in,
	input wire logic wfi_in,
	input wire logic halt_in,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] x_in,
	input wire logic [7:0] a_in,
	input wire logic [7:0] ccr_flags_in,
	input wire logic [7:0] stack_rdata_in,
	output logic stack_we_out,
	output logic stack_re_out,
	output logic [15:0] stack_addr_out,
	output logic [7:0] stack_wdata_out,
	output logic pc_load_out,
	output logic [15:0] pc_value_out,
	output logic [7:0] x_restore_out,
	output logic [7:0] a_restore_out,
	output logic ctx_restore_out,
	output logic vec_fetch_out,
	output logic cpu_stall_out,
	output logic in_wait_out,
	output logic in_halt_out,
	output logic [7:0] ccr_out
);
	////////////////////////////////////////////////////////////////////////
	cis_state_t state_reg;
	logic [7:0] ccr_reg;
	logic [7:0] sp_reg;
	logic [2:0] cnt_reg;
	logic [1:0] misc_reg;
	logic [3:0] sens_reg;
	logic [CIS_PERI_N-1:0] pen_reg, pflag_reg, armed_reg;
	logic [2*CIS_NAND_W-1:0] pinen_reg;
	logic [CIS_EXT_N-1:0] ext_pend_reg, ext_prev_reg;
	logic [CIS_EXT_N-1:0] s1_reg, s2_reg, s3_reg, ext_lvl_reg;
	logic [2:0] sel_reg;
	logic is_trap_reg, boot_reg;
	logic [7:0] ctx_x_reg, ctx_a_reg;
	logic [15:0] ctx_pc_reg;
	logic [CIS_EXT_N-1:0] nand_src, ext_req, ext_edge, ext_ev;
	logic [CIS_SRC_N-1:0] req, wake;
	logic [2:0] sel;
	logic any_req;
	logic wr_acc, rd_acc;
	logic mask;
	assign mask = ccr_reg[CIS_CCR_I];

	////////////////////////////////////////////////////////////////////////
	// shared-vector pins: a low on any enabled pin forces the nand high; with no pin
	// enabled the source sits high, so no low-level request follows reset
	always_comb begin
		nand_src[0] = ~&(pin_a_in | ~pinen_reg[CIS_NAND_W-1:0]);
		nand_src[1] = ~&(pin_b_in | ~pinen_reg[2*CIS_NAND_W-1:CIS_NAND_W]);
		if (pinen_reg[CIS_NAND_W-1:0] == '0)
			nand_src[0] = 1'b1;
		if (pinen_reg[2*CIS_NAND_W-1:CIS_NAND_W] == '0)
			nand_src[1] = 1'b1;
	end

	// pins are asynchronous: three stages, a change counts when 2nd and 3rd agree
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
			ext_lvl_reg <= '1;
			ext_prev_reg <= '1;
		end else if (ce_in) begin
			s1_reg <= nand_src;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < CIS_EXT_N; i++) begin
				if (s2_reg[i] == s3_reg[i])
					ext_lvl_reg[i] <= s3_reg[i];
			end
			ext_prev_reg <= ext_lvl_reg;
		end
	end

	// sensitivity: per source two bits in the misc register
	always_comb begin
		for (int i = 0; i < CIS_EXT_N; i++) begin
			unique case (sens_reg[2*i +: 2])
				CIS_SENS_FALL_LOW: ext_edge[i] = 1'b0;
				CIS_SENS_RISE: ext_edge[i] = ext_lvl_reg[i] & ~ext_prev_reg[i];
				CIS_SENS_FALL: ext_edge[i] = ~ext_lvl_reg[i] & ext_prev_reg[i];
				CIS_SENS_BOTH: ext_edge[i] = ext_lvl_reg[i] ^ ext_prev_reg[i];
			endcase
			// falling edge and low level: the level keeps requesting
			ext_ev[i] = (sens_reg[2*i +: 2] == CIS_SENS_FALL_LOW) ? ~ext_lvl_reg[i] : 1'b0;
			ext_req[i] = ext_pend_reg[i] | ext_ev[i];
		end
	end

	// edge latch; entry of its own routine clears it, a new edge wins
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ext_pend_reg <= '0;
		end else if (ce_in) begin
			for (int i = 0; i < CIS_EXT_N; i++) begin
				if (ext_edge[i])
					ext_pend_reg[i] <= 1'b1;
				else if (state_reg == CIS_VEC && cnt_reg == CIS_VEC_FETCH_CYC && !is_trap_reg
						&& sel_reg == 3'(i))
					ext_pend_reg[i] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// peripheral flags: latched regardless of mask or enable
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pflag_reg <= '0;
			armed_reg <= '0;
		end else if (ce_in) begin
			for (int i = 0; i < CIS_PERI_N; i++) begin
				if (peri_event_in[i]) begin
					pflag_reg[i] <= 1'b1;
					armed_reg[i] <= 1'b0;
				end else if (wr_acc && paddr_in == CIS_APB_PFLAG && !pwdata_in[i]) begin
					pflag_reg[i] <= 1'b0;
					armed_reg[i] <= 1'b0;
				end else if (armed_reg[i] && peri_assoc_in[i]) begin
					pflag_reg[i] <= 1'b0;
					armed_reg[i] <= 1'b0;
				end else if (rd_acc && paddr_in == CIS_APB_PFLAG && pflag_reg[i]) begin
					armed_reg[i] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// requests and fixed priority: lower index is higher priority
	always_comb begin
		req = {pflag_reg & pen_reg, ext_req};
		wake = req & CIS_HALT_WAKE;
		any_req = |req;
		sel = 3'h0;
		for (int i = CIS_SRC_N - 1; i >= 0; i--) begin
			if (req[i])
				sel = 3'(i);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= CIS_VEC;
			cnt_reg <= CIS_VEC_FETCH_CYC;
			boot_reg <= 1'b1;
			is_trap_reg <= 1'b0;
			sel_reg <= '0;
			ctx_pc_reg <= '0;
			ctx_x_reg <= '0;
			ctx_a_reg <= '0;
		end else if (ce_in) begin
			unique case (state_reg)
				CIS_RUN: begin
					if (instr_end_in) begin
						if (trap_in) begin
							state_reg <= CIS_PUSH;
							is_trap_reg <= 1'b1;
							cnt_reg <= CIS_PUSH_BYTES;
						end else if (return_from_interrupt_instruction_in) begin
							state_reg <= CIS_POP;
							cnt_reg <= CIS_PUSH_BYTES;
						end else if (any_req && !mask) begin
							state_reg <= CIS_PUSH;
							is_trap_reg <= 1'b0;
							sel_reg <= sel;
							cnt_reg <= CIS_PUSH_BYTES;
						end else if (wfi_in) begin
							state_reg <= CIS_WAIT;
						end else if (halt_in) begin
							state_reg <= CIS_HALT;
						end
						ctx_pc_reg <= pc_in;
						ctx_x_reg <= x_in;
						ctx_a_reg <= a_in;
					end
				end
				CIS_PUSH: begin
					cnt_reg <= cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_reg <= CIS_VEC;
						cnt_reg <= CIS_VEC_FETCH_CYC;
					end
				end
				CIS_VEC: begin
					cnt_reg <= cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_reg <= CIS_RUN;
						boot_reg <= 1'b0;
					end
				end
				CIS_POP: begin
					cnt_reg <= cnt_reg - 3'h1;
					unique case (cnt_reg)
						3'h4: ctx_a_reg <= stack_rdata_in;
						3'h3: ctx_x_reg <= stack_rdata_in;
						3'h2: ctx_pc_reg[15:8] <= stack_rdata_in;
						3'h1: ctx_pc_reg[7:0] <= stack_rdata_in;
						default: ;
					endcase
					if (cnt_reg == 3'h1)
						state_reg <= CIS_RUN;
				end
				CIS_WAIT: if (any_req) begin
					state_reg <= CIS_PUSH;
					is_trap_reg <= 1'b0;
					sel_reg <= sel;
					cnt_reg <= CIS_PUSH_BYTES;
				end
				CIS_HALT: if (|wake) begin
					state_reg <= CIS_PUSH;
					is_trap_reg <= 1'b0;
					sel_reg <= sel;
					cnt_reg <= CIS_PUSH_BYTES;
				end
				default: state_reg <= CIS_RUN;
			endcase
		end
	end

	// condition code register; mask bit owned by hardware and software
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ccr_reg <= CIS_CCR_RESET;
		end else if (ce_in) begin
			if (state_reg == CIS_PUSH && cnt_reg == 3'h1)
				ccr_reg[CIS_CCR_I] <= 1'b1;
			else if (state_reg == CIS_POP && cnt_reg == CIS_PUSH_BYTES) begin
				ccr_reg <= stack_rdata_in;
				ccr_reg[CIS_CCR_I] <= 1'b0;
			end else if (state_reg == CIS_RUN && instr_end_in && !trap_in && !return_from_interrupt_instruction_in
					&& !(any_req && !mask) && (wfi_in || halt_in))
				ccr_reg[CIS_CCR_I] <= 1'b0;
			else if (wr_acc && paddr_in == CIS_APB_CCR)
				ccr_reg <= pwdata_in[7:0];
			else if (state_reg == CIS_RUN && instr_end_in)
				ccr_reg <= {ccr_reg[7:4], ccr_reg[CIS_CCR_I], ccr_flags_in[2:0]};
		end
	end

	// stack pointer: 128-byte page 0x00..0x7f, wraps in the low seven bits
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sp_reg <= CIS_SP_RESET;
		end else if (ce_in) begin
			if (state_reg == CIS_PUSH)
				sp_reg <= {1'b0, sp_reg[6:0] - 7'h1};
			else if (state_reg == CIS_POP)
				sp_reg <= {1'b0, sp_reg[6:0] + 7'h1};
		end
	end

	// stack port: pushes pcl, pch, x, a, ccr; y is never saved
	always_comb begin
		stack_we_out = (state_reg == CIS_PUSH);
		stack_re_out = (state_reg == CIS_POP);
		stack_addr_out = (state_reg == CIS_POP) ?
			{CIS_SP_STACK_MSB, 1'b0, sp_reg[6:0] + 7'h1} : {CIS_SP_STACK_MSB, sp_reg};
		unique case (cnt_reg)
			3'h5: stack_wdata_out = ctx_pc_reg[7:0];
			3'h4: stack_wdata_out = ctx_pc_reg[15:8];
			3'h3: stack_wdata_out = ctx_x_reg;
			3'h2: stack_wdata_out = ctx_a_reg;
			default: stack_wdata_out = ccr_reg;
		endcase
	end

	// vector selection
	always_comb begin
		if (boot_reg)
			pc_value_out = CIS_VEC_RESET;
		else if (is_trap_reg)
			pc_value_out = CIS_VEC_TRAP;
		else
			pc_value_out = CIS_VEC_BASE - CIS_VEC_STEP * {13'h0, sel_reg};
		// low byte straight from the stack, so the pc is whole on the last pop cycle
		if (state_reg == CIS_POP)
			pc_value_out = {ctx_pc_reg[15:8], stack_rdata_in};
	end

	assign vec_fetch_out = (state_reg == CIS_VEC);
	assign pc_load_out = (state_reg == CIS_VEC && cnt_reg == 3'h1);
	assign ctx_restore_out = (state_reg == CIS_POP && cnt_reg == 3'h1);
	assign x_restore_out = ctx_x_reg;
	assign a_restore_out = ctx_a_reg;
	assign cpu_stall_out = (state_reg != CIS_RUN);
	assign in_wait_out = (state_reg == CIS_WAIT);
	assign in_halt_out = (state_reg == CIS_HALT);
	assign ccr_out = ccr_reg;

	////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	assign wr_acc = ce_in && psel_in && penable_in && pwrite_in;
	assign rd_acc = ce_in && psel_in && penable_in && !pwrite_in;
	assign pready_out = 1'b1;

	always_comb begin
		pslverr_out = 1'b0;
		prdata_out = '0;
		unique case (paddr_in)
			CIS_APB_CCR: prdata_out = {24'h0, ccr_reg};
			CIS_APB_MISC: prdata_out = {24'h0, misc_reg, 2'h0, sens_reg};
			CIS_APB_PEN: prdata_out = {26'h0, pen_reg};
			CIS_APB_PFLAG: prdata_out = {26'h0, pflag_reg};
			CIS_APB_PINEN: prdata_out = {16'h0, pinen_reg};
			CIS_APB_STAT: prdata_out = {24'h0, 1'b0, sel_reg, ext_pend_reg, 1'b0, 1'(state_reg != CIS_RUN)};
			CIS_APB_SP: prdata_out = {24'h0, sp_reg};
			default: pslverr_out = psel_in && penable_in;
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sens_reg <= '0;
			misc_reg <= '0;
			pen_reg <= '0;
			pinen_reg <= '0;
		end else if (wr_acc) begin
			if (paddr_in == CIS_APB_MISC) begin
				sens_reg <= pwdata_in[3:0];
				misc_reg <= pwdata_in[7:6];
			end
			if (paddr_in == CIS_APB_PEN)
				pen_reg <= pwdata_in[CIS_PERI_N-1:0];
			if (paddr_in == CIS_APB_PINEN)
				pinen_reg <= pwdata_in[2*CIS_NAND_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	mask_set_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		ce_in && state_reg == CIS_PUSH && cnt_reg == 3'h1 |=> mask)
		else $error("mask not set on entry");
	push_len_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		ce_in && $rose(stack_we_out) |-> stack_we_out[*5])
		else $error("push not five bytes");
	vec_len_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		ce_in && $rose(vec_fetch_out) |-> vec_fetch_out[*2])
		else $error("vector fetch not two cycles");
	masked_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		state_reg == CIS_RUN && mask && !trap_in |=> state_reg != CIS_PUSH)
		else $error("maskable taken while masked");
	trap_take_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		ce_in && state_reg == CIS_RUN && instr_end_in && trap_in |=> state_reg == CIS_PUSH)
		else $error("trap not taken");
	return_from_interrupt_instruction_mask_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		ce_in && state_reg == CIS_POP && cnt_reg == CIS_PUSH_BYTES |=> !mask)
		else $error("mask not cleared by return");
	halt_wake_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		state_reg == CIS_HALT && wake == '0 |=> state_reg == CIS_HALT)
		else $error("halt left without capable source");
	wait_wake_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		ce_in && state_reg == CIS_WAIT && any_req |=> state_reg == CIS_PUSH)
		else $error("wait not woken");
	wait_mask_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		ce_in && $rose(in_wait_out) |-> !mask)
		else $error("mask set in wait");
endmodule

// ===== cis_stack_mem.sv
`timescale 1ns/1ps
// stack ram on the far side of the sequencer, read combinationally
module cis_stack_mem (
	input wire logic mclk_in,
	input wire logic we_in,
	input wire logic re_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [256];
	logic [7:0] last_reg;
	// released bus shows the inverse of the last byte, so stale data never looks valid
	assign rdata_out = re_in ? mem[addr_in[7:0]] : ~last_reg;
	always_ff @(posedge mclk_in) begin
		if (we_in) begin
			mem[addr_in[7:0]] <= wdata_in;
		end
		if (re_in) begin
			last_reg <= mem[addr_in[7:0]];
		end
	end
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
	import cis_pkg::*;
	logic mclk_in = 0, rst_in = 1, ce_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic [11:0] paddr_in = '0;
	logic [31:0] pwdata_in = '0, prdata_out;
	logic pready_out, pslverr_out, stack_we_out, stack_re_out, pc_load_out, ctx_restore_out;
	logic vec_fetch_out, cpu_stall_out, in_wait_out, in_halt_out;
	logic [CIS_NAND_W-1:0] pin_a_in = 8'hff, pin_b_in = 8'hff;
	logic [CIS_PERI_N-1:0] peri_event_in = '0, peri_assoc_in = '0;
	logic instr_end_in = 0, trap_in = 0, return_from_interrupt_instruction_in = 0, wfi_in = 0, halt_in = 0;
	logic [15:0] pc_in = '0, stack_addr_out, pc_value_out, lpc, p1, p2, ev;
	logic [7:0] x_in = '0, a_in = '0, ccr_flags_in = '0, stack_rdata_in, stack_wdata_out;
	logic [7:0] x_restore_out, a_restore_out, ccr_out, lx, la, x2, a2;
	logic [31:0] seed = 32'h3c, r;
	logic [64:0] re;
	logic [64:0] exp_rd [$];
	logic [15:0] exp_vec [$];
	logic [15:0] exp_ret [$];
	int n_mismatch = 0, checks_done = 0, cyc = 0, nv = 0;
	cis_sequencer u_dut (
		.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
		.peri_event_in(peri_event_in), .peri_assoc_in(peri_assoc_in),
		.instr_end_in(instr_end_in), .trap_in(trap_in), .return_from_interrupt_instruction_in(return_from_interrupt_instruction_in),
		.wfi_in(wfi_in), .halt_in(halt_in),
		.pc_in(pc_in), .x_in(x_in), .a_in(a_in), .ccr_flags_in(ccr_flags_in),
		.stack_rdata_in(stack_rdata_in), .stack_we_out(stack_we_out),
		.stack_re_out(stack_re_out), .stack_addr_out(stack_addr_out),
		.stack_wdata_out(stack_wdata_out), .pc_load_out(pc_load_out),
		.pc_value_out(pc_value_out), .x_restore_out(x_restore_out),
		.a_restore_out(a_restore_out), .ctx_restore_out(ctx_restore_out),
		.vec_fetch_out(vec_fetch_out), .cpu_stall_out(cpu_stall_out),
		.in_wait_out(in_wait_out), .in_halt_out(in_halt_out), .ccr_out(ccr_out)
	);
	cis_stack_mem u_mem (.mclk_in(mclk_in), .we_in(stack_we_out), .re_in(stack_re_out),
		.addr_in(stack_addr_out), .wdata_in(stack_wdata_out), .rdata_out(stack_rdata_in));
	always #12.5 mclk_in = ~mclk_in;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] vec(input int s);
		return CIS_VEC_BASE - CIS_VEC_STEP * 16'(s);
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1;
		// only the bench timeout ends a wait for the answer
		@(posedge mclk_in);
		while (pready_out !== 1'b1)
			@(posedge mclk_in);
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic err);
		exp_rd.push_back({err, m, e});
		apb(1'b0, a, 32'h0);
	endtask
	// q is {trap, return, wait, halt}; context values are random
	task automatic instr(input logic [3:0] q);
		@(posedge mclk_in);
		r = xs();
		lpc = r[15:0];
		lx = r[23:16];
		la = r[31:24];
		pc_in <= lpc;
		x_in <= lx;
		a_in <= la;
		instr_end_in <= 1;
		{trap_in, return_from_interrupt_instruction_in, wfi_in, halt_in} <= q;
		@(posedge mclk_in);
		instr_end_in <= 0;
		{trap_in, return_from_interrupt_instruction_in, wfi_in, halt_in} <= 4'h0;
	endtask
	task automatic idle();
		@(negedge mclk_in);
		while (cpu_stall_out !== 1'b0)
			@(negedge mclk_in);
	endtask
	task automatic pev(input int i);
		@(posedge mclk_in);
		peri_event_in <= 6'h01 << i;
		@(posedge mclk_in);
		peri_event_in <= 6'h00;
	endtask
	task automatic results();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
		if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
			re = exp_rd.size() > 0 ? exp_rd.pop_front() : {65{1'bx}};
			`CHK("read data", re[31:0], prdata_out & re[63:32])
			`CHK("read error", re[64], pslverr_out)
		end
		if (!rst_in && pc_load_out === 1'b1 && vec_fetch_out === 1'b1) begin
			ev = exp_vec.size() > 0 ? exp_vec.pop_front() : 16'hxxxx;
			`CHK("vector", ev, pc_value_out)
		end
		if (!rst_in && ctx_restore_out === 1'b1 && exp_ret.size() > 0) begin
			`CHK("return pc", exp_ret.pop_front(), pc_value_out)
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		exp_vec.push_back(CIS_VEC_RESET);
		repeat (8) @(posedge mclk_in);
		rst_in <= 0;
		repeat (4) begin
			@(negedge mclk_in);
			nv += (vec_fetch_out === 1'b1);
		end
		`CHK("fetch cycles", 2, nv)
		`CHK("mask at reset", 1'b1, ccr_out[CIS_CCR_I])
		// a write while the clock enable is low must leave the mask as reset put it
		@(posedge mclk_in);
		ce_in <= 0;
		apb(1'b1, CIS_APB_CCR, 32'h0);
		ce_in <= 1;
		rd(CIS_APB_CCR, 32'he8, 32'hff, 1'b0);
		rd(12'h020, 32'h0, 32'hffffffff, 1'b1);
		exp_vec.push_back(CIS_VEC_TRAP);
		instr(4'h8);
		idle();
		`CHK("pushed pcl", lpc[7:0], u_mem.mem[8'h7f])
		`CHK("pushed pch", lpc[15:8], u_mem.mem[8'h7e])
		`CHK("pushed x", lx, u_mem.mem[8'h7d])
		`CHK("pushed a", la, u_mem.mem[8'h7c])
		`CHK("pushed ccr", 8'he8, u_mem.mem[8'h7b])
		exp_ret.push_back(lpc);
		x2 = lx;
		a2 = la;
		instr(4'h4);
		idle();
		`CHK("x restored", x2, x_restore_out)
		`CHK("a restored", a2, a_restore_out)
		`CHK("mask after return", 1'b0, ccr_out[CIS_CCR_I])
		pev(1);
		pev(0);
		instr(4'h0);
		idle();
		rd(CIS_APB_PFLAG, 32'h3, 32'h3f, 1'b0);
		apb(1'b1, CIS_APB_PEN, 32'h3);
		repeat (5) @(negedge mclk_in);
		`CHK("stall before end", 1'b0, cpu_stall_out)
		exp_vec.push_back(vec(2));
		instr(4'h0);
		idle();
		p1 = lpc;
		`CHK("mask on entry", 1'b1, ccr_out[CIS_CCR_I])
		instr(4'h0);
		idle();
		apb(1'b1, CIS_APB_PFLAG, 32'h3e);
		apb(1'b1, CIS_APB_CCR, 32'he0);
		exp_vec.push_back(vec(3));
		instr(4'h0);
		idle();
		p2 = lpc;
		apb(1'b1, CIS_APB_PFLAG, 32'h3c);
		exp_ret.push_back(p2);
		exp_ret.push_back(p1);
		instr(4'h4);
		idle();
		instr(4'h4);
		idle();
		pev(2);
		rd(CIS_APB_PFLAG, 32'h4, 32'h4, 1'b0);
		@(posedge mclk_in);
		peri_assoc_in <= 6'h04;
		@(posedge mclk_in);
		peri_assoc_in <= 6'h00;
		rd(CIS_APB_PFLAG, 32'h0, 32'h4, 1'b0);
		apb(1'b1, CIS_APB_PEN, 32'h10);
		apb(1'b1, CIS_APB_CCR, 32'he8);
		instr(4'h2);
		repeat (3) @(negedge mclk_in);
		`CHK("in wait", 1'b1, in_wait_out)
		`CHK("mask in wait", 1'b0, ccr_out[CIS_CCR_I])
		exp_vec.push_back(vec(6));
		pev(4);
		idle();
		`CHK("left wait", 1'b0, in_wait_out)
		apb(1'b1, CIS_APB_PFLAG, 32'h0);
		instr(4'h4);
		idle();
		instr(4'h1);
		repeat (3) @(negedge mclk_in);
		`CHK("mask in halt", 1'b0, ccr_out[CIS_CCR_I])
		pev(4);
		repeat (8) @(negedge mclk_in);
		`CHK("peripheral kept halt", 1'b1, in_halt_out)
		exp_vec.push_back(vec(0));
		apb(1'b1, CIS_APB_MISC, {30'h0, CIS_SENS_RISE});
		apb(1'b1, CIS_APB_PINEN, 32'h1);
		repeat (8) @(negedge mclk_in);
		`CHK("enable kept halt", 1'b1, in_halt_out)
		@(posedge mclk_in);
		pin_a_in <= 8'hfe;
		idle();
		`CHK("left halt", 1'b0, in_halt_out)
		rd(CIS_APB_STAT, 32'h0, 32'h4, 1'b0);
		`CHK("vectors left", 0, exp_vec.size())
		`CHK("returns left", 0, exp_ret.size())
		results();
	end
endmodule
